// ==== logic/icl_spi_slave.sv ====
// Serial command slave of a dual-axis inclinometer, with its sample bank.
// Assumes chip select, serial clock and serial data arrive asynchronously
// and that the serial clock is far slower than the system clock.
`timescale 1ns/10ps
module icl_spi_slave #(
  parameter int ACC_W = icl_pkg::ACC_BITS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  input wire logic [ACC_W-1:0] x_accel_in,
  input wire logic [ACC_W-1:0] y_accel_in,
  input wire logic [icl_pkg::TEMP_BITS-1:0] temp_in,
  output logic self_test_x,
  output logic self_test_y,
  output logic measure_mode
);

  if (ACC_W < icl_pkg::TEMP_BITS || ACC_W >= (1 << icl_pkg::CNT_W))
  begin : g_chk_width
    $error("Result width unsupported by the shift counter.");
  end

  localparam logic [icl_pkg::CNT_W-1:0] ACC_LEN =
    icl_pkg::CNT_W'(ACC_W);

  icl_rd_if #(.W(ACC_W)) rd_bus ();

  icl_sample_bank #(.ACC_W(ACC_W)) u_bank (
    .sys_clk(sys_clk),
    .reset(reset),
    .rd(rd_bus),
    .x_accel_in(x_accel_in),
    .y_accel_in(y_accel_in),
    .temp_in(temp_in)
  );

  // Pin synchronisers. Edges are judged between the second and third
  // stages so the first stage feeds nothing but the second.
  logic csn_s1_r, csn_s2_r, csn_s3_r;
  logic sck_s1_r, sck_s2_r, sck_s3_r;
  logic mosi_s1_r, mosi_s2_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      csn_s1_r <= icl_pkg::SYNC_HI;
      csn_s2_r <= icl_pkg::SYNC_HI;
      csn_s3_r <= icl_pkg::SYNC_HI;
      sck_s1_r <= icl_pkg::SYNC_LO;
      sck_s2_r <= icl_pkg::SYNC_LO;
      sck_s3_r <= icl_pkg::SYNC_LO;
      mosi_s1_r <= icl_pkg::SYNC_LO;
      mosi_s2_r <= icl_pkg::SYNC_LO;
    end else begin
      csn_s1_r <= chip_select_n;
      csn_s2_r <= csn_s1_r;
      csn_s3_r <= csn_s2_r;
      sck_s1_r <= sck;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      mosi_s1_r <= mosi;
      mosi_s2_r <= mosi_s1_r;
    end
  end

  logic selected, cs_fall, cs_rise, sck_rise, sck_fall;

  always_comb begin
    selected = !csn_s2_r;
    cs_fall = csn_s3_r && !csn_s2_r;
    cs_rise = !csn_s3_r && csn_s2_r;
    // Clock edges count only inside a frame.
    sck_rise = selected && !cs_fall && !sck_s3_r && sck_s2_r;
    sck_fall = selected && !cs_fall && sck_s3_r && !sck_s2_r;
  end

  // Frame state.
  icl_pkg::icl_state_t state_r, state_nxt;
  logic [icl_pkg::CNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
  logic [icl_pkg::CNT_W-1:0] out_cnt_r, out_cnt_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [ACC_W-1:0] shift_r, shift_nxt;
  logic miso_r, miso_nxt, oe_r, oe_nxt;
  logic load_pend_r, load_pend_nxt;
  icl_pkg::icl_sel_t sel_r, sel_nxt;
  logic st_x_r, st_x_nxt, st_y_r, st_y_nxt;
  logic [7:0] cmd_full;
  icl_pkg::icl_op_t op_full;
  logic cmd_done;

  always_comb begin
    cmd_full = {cmd_r[icl_pkg::CMD_BITS-2:0], mosi_s2_r};
    op_full = icl_pkg::decode(cmd_full);
    cmd_done = sck_rise && state_r == icl_pkg::ST_CMD &&
               bit_cnt_r == icl_pkg::CMD_LAST;
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    out_cnt_nxt = out_cnt_r;
    cmd_nxt = cmd_r;
    shift_nxt = shift_r;
    miso_nxt = miso_r;
    oe_nxt = oe_r;
    load_pend_nxt = load_pend_r;
    sel_nxt = sel_r;
    st_x_nxt = st_x_r;
    st_y_nxt = st_y_r;
    if (!selected) begin
      // Deselect aborts everything and clears counter and command.
      state_nxt = icl_pkg::ST_IDLE;
      bit_cnt_nxt = icl_pkg::CNT_ZERO;
      cmd_nxt = icl_pkg::BYTE_ZERO;
      out_cnt_nxt = icl_pkg::CNT_ZERO;
      oe_nxt = 1'b0;
      miso_nxt = 1'b0;
      load_pend_nxt = 1'b0;
    end else if (cs_fall) begin
      state_nxt = icl_pkg::ST_CMD;
      bit_cnt_nxt = icl_pkg::CNT_ZERO;
      cmd_nxt = icl_pkg::BYTE_ZERO;
    end else begin
      unique case (state_r)
        icl_pkg::ST_IDLE: begin
          state_nxt = icl_pkg::ST_IDLE;
        end
        icl_pkg::ST_CMD: begin
          if (sck_rise) begin
            cmd_nxt = cmd_full;
            bit_cnt_nxt = bit_cnt_r + icl_pkg::CNT_ONE;
            if (cmd_done) begin
              sel_nxt = icl_pkg::sel_of(op_full);
              out_cnt_nxt = icl_pkg::resp_len(op_full, ACC_LEN);
              load_pend_nxt = 1'b1;
              unique case (op_full)
                icl_pkg::OP_BAD: state_nxt = icl_pkg::ST_LOCK;
                default: state_nxt = icl_pkg::ST_DATA;
              endcase
              unique case (op_full)
                icl_pkg::OP_MEASURE: begin
                  st_x_nxt = 1'b0;
                  st_y_nxt = 1'b0;
                end
                icl_pkg::OP_SELF_TEST_X: st_x_nxt = 1'b1;
                icl_pkg::OP_SELF_TEST_Y: st_y_nxt = 1'b1;
                default: st_x_nxt = st_x_r;
              endcase
            end
          end
        end
        icl_pkg::ST_DATA: begin
          // Incoming data bits keep clocking with no gap and are not
          // stored; the temperature register is never written.
          if (sck_fall && out_cnt_r != icl_pkg::CNT_ZERO) begin
            oe_nxt = 1'b1;
            out_cnt_nxt = out_cnt_r - icl_pkg::CNT_ONE;
            if (load_pend_r) begin
              miso_nxt = rd_bus.data[ACC_W-1];
              shift_nxt = {rd_bus.data[ACC_W-2:0], 1'b0};
              load_pend_nxt = 1'b0;
            end else begin
              miso_nxt = shift_r[ACC_W-1];
              shift_nxt = {shift_r[ACC_W-2:0], 1'b0};
            end
          end else if (sck_fall && oe_r) begin
            miso_nxt = 1'b0;
          end
        end
        icl_pkg::ST_LOCK: begin
          // Only deselection leaves this state, returning it to ST_IDLE.
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= icl_pkg::ST_IDLE;
      bit_cnt_r <= icl_pkg::CNT_ZERO;
      out_cnt_r <= icl_pkg::CNT_ZERO;
      cmd_r <= icl_pkg::BYTE_ZERO;
      shift_r <= '0;
      miso_r <= 1'b0;
      oe_r <= 1'b0;
      load_pend_r <= 1'b0;
      sel_r <= icl_pkg::SEL_X;
      st_x_r <= 1'b0;
      st_y_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      out_cnt_r <= out_cnt_nxt;
      cmd_r <= cmd_nxt;
      shift_r <= shift_nxt;
      miso_r <= miso_nxt;
      oe_r <= oe_nxt;
      load_pend_r <= load_pend_nxt;
      sel_r <= sel_nxt;
      st_x_r <= st_x_nxt;
      st_y_r <= st_y_nxt;
    end
  end

  // The bank freezes its contents for the whole frame.
  assign rd_bus.hold = selected;
  assign rd_bus.sel = sel_r;
  assign miso_o = miso_r;
  assign miso_oe = oe_r;
  assign self_test_x = st_x_r;
  assign self_test_y = st_y_r;
  assign measure_mode = !st_x_r && !st_y_r;

  property p_deselect_clear;
    @(posedge sys_clk) disable iff (reset)
      cs_rise |=> state_r == icl_pkg::ST_IDLE && !miso_oe &&
                  bit_cnt_r == icl_pkg::CNT_ZERO &&
                  cmd_r == icl_pkg::BYTE_ZERO;
  endproperty
  a_deselect_clear: assert property (p_deselect_clear)
    else $error("Deselect did not clear the frame state.");

  property p_quiet_unselected;
    @(posedge sys_clk) disable iff (reset)
      (csn_s2_r && csn_s3_r) |-> !miso_oe && state_r == icl_pkg::ST_IDLE;
  endproperty
  a_quiet_unselected: assert property (p_quiet_unselected)
    else $error("Output driven while deselected.");

  property p_frame_start;
    @(posedge sys_clk) disable iff (reset)
      cs_fall |=> state_r == icl_pkg::ST_CMD && !miso_oe;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("Select did not open a command phase.");

  property p_capture_msb_first;
    @(posedge sys_clk) disable iff (reset)
      (sck_rise && state_r == icl_pkg::ST_CMD) |=>
        cmd_r == {$past(cmd_r[icl_pkg::CMD_BITS-2:0]),
                  $past(mosi_s2_r)} &&
        bit_cnt_r == $past(bit_cnt_r) + icl_pkg::CNT_ONE;
  endproperty
  a_capture_msb_first: assert property (p_capture_msb_first)
    else $error("Command bit not captured on the rising edge.");

  property p_first_bit;
    @(posedge sys_clk) disable iff (reset)
      (state_r == icl_pkg::ST_DATA && load_pend_r && sck_fall &&
       out_cnt_r != icl_pkg::CNT_ZERO) |=>
        miso_oe && miso_o == $past(rd_bus.data[ACC_W-1]);
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("First answer bit not driven at the first falling edge.");

  property p_change_on_fall;
    @(posedge sys_clk) disable iff (reset)
      (miso_oe && $past(miso_oe) && $changed(miso_o)) |->
        $past(sck_fall);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall)
    else $error("Output bit changed away from a falling clock edge.");

  property p_shift_next;
    @(posedge sys_clk) disable iff (reset)
      (state_r == icl_pkg::ST_DATA && !load_pend_r && sck_fall &&
       out_cnt_r != icl_pkg::CNT_ZERO) |=>
        miso_o == $past(shift_r[ACC_W-1]);
  endproperty
  a_shift_next: assert property (p_shift_next)
    else $error("Answer bit out of order.");

  property p_bad_lock;
    @(posedge sys_clk) disable iff (reset)
      (cmd_done && selected && !cs_fall && op_full == icl_pkg::OP_BAD)
        |=> state_r == icl_pkg::ST_LOCK ##1 !miso_oe;
  endproperty
  a_bad_lock: assert property (p_bad_lock)
    else $error("Unknown command did not lock the frame.");

  property p_measure_ends_test;
    @(posedge sys_clk) disable iff (reset)
      (cmd_done && selected && !cs_fall && op_full == icl_pkg::OP_MEASURE)
        |=> measure_mode && !self_test_x && !self_test_y;
  endproperty
  a_measure_ends_test: assert property (p_measure_ends_test)
    else $error("Measure command did not end self-test.");

  property p_self_test_start;
    @(posedge sys_clk) disable iff (reset)
      (cmd_done && selected && !cs_fall && op_full == icl_pkg::OP_SELF_TEST_Y)
        |=> self_test_y && $stable(self_test_x);
  endproperty
  a_self_test_start: assert property (p_self_test_start)
    else $error("Self-test command did not take effect.");

  property p_read_length;
    @(posedge sys_clk) disable iff (reset)
      (cmd_done && selected && !cs_fall &&
       (op_full == icl_pkg::OP_RDX || op_full == icl_pkg::OP_RDY))
        |=> out_cnt_r == ACC_LEN && sel_r != icl_pkg::SEL_T;
  endproperty
  a_read_length: assert property (p_read_length)
    else $error("Acceleration answer length or source wrong.");

  property p_temp_select;
    @(posedge sys_clk) disable iff (reset)
      (cmd_done && selected && !cs_fall && op_full == icl_pkg::OP_TEMP)
        |=> sel_r == icl_pkg::SEL_T && out_cnt_r == icl_pkg::LEN_TEMP;
  endproperty
  a_temp_select: assert property (p_temp_select)
    else $error("Temperature read set up wrongly.");

  property p_read_y_source;
    @(posedge sys_clk) disable iff (reset)
      (cmd_done && op_full == icl_pkg::OP_RDY) |=> sel_r == icl_pkg::SEL_Y;
  endproperty
  a_read_y_source: assert property (p_read_y_source)
    else $error("Y acceleration read selected the wrong source.");

endmodule

// ==== logic/icl_pkg.sv ====
// Shared constants, types and decode helpers for the inclinometer SPI slave.
// Assumes a single 20 MHz system clock drives every module that uses it.
package icl_pkg;

  localparam int CMD_BITS = 8;
  localparam int ACC_BITS = 11;
  localparam int TEMP_BITS = 8;
  localparam int CNT_W = 4;

  localparam logic [7:0] CMD_MEASURE = 8'h00;
  localparam logic [7:0] CMD_TEMP = 8'h08;
  localparam logic [7:0] CMD_SELF_TEST_X = 8'h0E;
  localparam logic [7:0] CMD_SELF_TEST_Y = 8'h0F;
  localparam logic [7:0] CMD_RDX = 8'h10;
  localparam logic [7:0] CMD_RDY = 8'h11;

  // Refresh period of the data registers and its length in clock cycles.
  localparam int REFRESH_US = 150;
  localparam int CLK_HZ = 20000000;
  localparam int REFRESH_CYC = REFRESH_US * (CLK_HZ / 1000000);
  localparam int TMR_W = 12;

  localparam logic SYNC_HI = 1'b1;
  localparam logic SYNC_LO = 1'b0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CMD_LAST = 4'h7;
  localparam logic [CNT_W-1:0] LEN_TEMP = 4'h8;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CMD = 4'h2,
    ST_DATA = 4'h4,
    ST_LOCK = 4'h8
  } icl_state_t;

  typedef enum logic [2:0] {
    OP_MEASURE = 3'h0,
    OP_TEMP = 3'h1,
    OP_SELF_TEST_X = 3'h2,
    OP_SELF_TEST_Y = 3'h3,
    OP_RDX = 3'h4,
    OP_RDY = 3'h5,
    OP_BAD = 3'h6
  } icl_op_t;

  typedef enum logic [1:0] {
    SEL_X = 2'h0,
    SEL_Y = 2'h1,
    SEL_T = 2'h2
  } icl_sel_t;

  function automatic icl_op_t decode(input logic [7:0] c);
    case (c)
      CMD_MEASURE: decode = OP_MEASURE;
      CMD_TEMP: decode = OP_TEMP;
      CMD_SELF_TEST_X: decode = OP_SELF_TEST_X;
      CMD_SELF_TEST_Y: decode = OP_SELF_TEST_Y;
      CMD_RDX: decode = OP_RDX;
      CMD_RDY: decode = OP_RDY;
      default: decode = OP_BAD;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] resp_len(input icl_op_t op,
                                                input logic [CNT_W-1:0] acc);
    case (op)
      OP_TEMP: resp_len = LEN_TEMP;
      OP_RDX, OP_RDY: resp_len = acc;
      default: resp_len = CNT_ZERO;
    endcase
  endfunction

  function automatic icl_sel_t sel_of(input icl_op_t op);
    case (op)
      OP_RDY: sel_of = SEL_Y;
      OP_TEMP: sel_of = SEL_T;
      default: sel_of = SEL_X;
    endcase
  endfunction

endpackage

// ==== logic/icl_rd_if.sv ====
// Read path between the serial core and the sample register bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface icl_rd_if #(parameter int W = icl_pkg::ACC_BITS);
  logic hold;
  icl_pkg::icl_sel_t sel;
  logic [W-1:0] data;
  modport core (output hold, output sel, input data);
  modport bank (input hold, input sel, output data);
endinterface

// ==== logic/icl_sample_bank.sv ====
// Holds the X, Y and temperature results and refreshes them periodically.
// Assumes converter results arrive on the system clock, already stable.
`timescale 1ns/10ps
module icl_sample_bank #(
  parameter int ACC_W = icl_pkg::ACC_BITS
) (
  input wire logic sys_clk,
  input wire logic reset,
  icl_rd_if.bank rd,
  input wire logic [ACC_W-1:0] x_accel_in,
  input wire logic [ACC_W-1:0] y_accel_in,
  input wire logic [icl_pkg::TEMP_BITS-1:0] temp_in
);

  localparam logic [icl_pkg::TMR_W-1:0] TMR_LAST =
    icl_pkg::TMR_W'(icl_pkg::REFRESH_CYC - 1);
  localparam int PAD_W = ACC_W - icl_pkg::TEMP_BITS;

  if (icl_pkg::REFRESH_CYC >= (1 << icl_pkg::TMR_W)) begin : g_chk_tmr
    $error("Refresh count does not fit the timer.");
  end

  logic [icl_pkg::TMR_W-1:0] tmr_r, tmr_nxt;
  logic [ACC_W-1:0] x_r, x_nxt, y_r, y_nxt, data_r, data_nxt;
  logic [icl_pkg::TEMP_BITS-1:0] t_r, t_nxt;
  logic tick;

  // The timer restarts whenever the frame holds the bank, so a full period
  // of deselection is needed before fresh data is guaranteed.
  always_comb begin
    tick = (tmr_r == TMR_LAST) && !rd.hold;
    tmr_nxt = (rd.hold || tick) ? '0 : tmr_r + 1'b1;
    x_nxt = tick ? x_accel_in : x_r;
    y_nxt = tick ? y_accel_in : y_r;
    t_nxt = tick ? temp_in : t_r;
    unique case (rd.sel)
      icl_pkg::SEL_Y: data_nxt = y_r;
      icl_pkg::SEL_T: data_nxt = {t_r, {PAD_W{1'b0}}};
      default: data_nxt = x_r;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tmr_r <= '0;
      x_r <= '0;
      y_r <= '0;
      t_r <= '0;
      data_r <= '0;
    end else begin
      tmr_r <= tmr_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
      t_r <= t_nxt;
      data_r <= data_nxt;
    end
  end

  assign rd.data = data_r;

  property p_hold_x;
    @(posedge sys_clk) disable iff (reset)
      rd.hold |=> $stable(x_r) && $stable(y_r) && $stable(t_r);
  endproperty
  a_hold_x: assert property (p_hold_x)
    else $error("Data registers changed while the frame is open.");

  property p_reload;
    @(posedge sys_clk) disable iff (reset)
      (tmr_r == TMR_LAST && !rd.hold) |=>
        x_r == $past(x_accel_in) && y_r == $past(y_accel_in) &&
        t_r == $past(temp_in);
  endproperty
  a_reload: assert property (p_reload)
    else $error("Data registers missed their periodic reload.");

endmodule

// ==== tb/icl_master_bfm.sv ====
// Behavioural SPI master that frames commands for the inclinometer slave.
// Assumes the bench resolves the serial output wire and passes it in.
`timescale 1ns/10ps
module icl_master_bfm (
  input wire logic sys_clk,
  output logic chip_select_n,
  output logic sck,
  output logic mosi,
  input wire logic miso,
  output logic rx_valid,
  output logic [15:0] rx_data
);
  // Half period of 25 cycles gives 400 kHz, under the serial clock limit.
  localparam int HALF = 25;

  initial begin
    chip_select_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    rx_valid = 1'b0;
    rx_data = 16'h0000;
  end

  // A released data line must not keep its last level between frames.
  always @(posedge sys_clk) begin
    if (chip_select_n) begin
      mosi <= ~mosi;
    end
  end

  // Sends nbits clocks: the command, then zeros, sampling nrx answer bits.
  task automatic frame(input logic [7:0] cmd, input int nbits,
                       input int nrx);
    chip_select_n <= 1'b0;
    rx_data <= 16'h0000;
    repeat (30) @(posedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      mosi <= (i < 8) ? cmd[7-i] : 1'b0;
      repeat (HALF) @(posedge sys_clk);
      sck <= 1'b1;
      if (i >= 8 && i < 8 + nrx) begin
        rx_data <= {rx_data[14:0], miso};
      end
      repeat (HALF) @(posedge sys_clk);
      sck <= 1'b0;
    end
    repeat (HALF) @(posedge sys_clk);
    chip_select_n <= 1'b1;
    rx_valid <= (nrx > 0);
    @(posedge sys_clk);
    rx_valid <= 1'b0;
  endtask

  // Clock pulses while deselected, which the slave must disregard.
  task automatic junk();
    for (int i = 0; i < 8; i++) begin
      repeat (HALF) @(posedge sys_clk);
      sck <= 1'b1;
      repeat (HALF) @(posedge sys_clk);
      sck <= 1'b0;
    end
  endtask
endmodule

// ==== tb/tb_inclinometer_spi_slave.sv ====
// Self-checking bench for the inclinometer SPI slave.
// Assumes the master model answers each frame that samples bits with its sampled word.
`timescale 1ns/10ps
module tb_inclinometer_spi_slave;
  logic sys_clk;
  logic reset;
  logic chip_select_n;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  wire logic miso_w;
  logic [10:0] x_accel_in;
  logic [10:0] y_accel_in;
  logic [7:0] temp_in;
  logic self_test_x;
  logic self_test_y;
  logic measure_mode;
  logic rx_valid;
  logic [15:0] rx_data;
  logic [15:0] exp_q[$];
  logic [15:0] ex;
  logic [15:0] ey;
  logic [15:0] et;
  logic [15:0] none_w;
  int failures;
  int tests_run;

  // Undriven output floats, so refused answers sample as high impedance.
  assign miso_w = miso_oe ? miso_o : 1'bz;

  icl_spi_slave u_icl_spi_slave (
    .sys_clk(sys_clk),
    .reset(reset),
    .chip_select_n(chip_select_n),
    .sck(sck),
    .mosi(mosi),
    .miso_o(miso_o),
    .miso_oe(miso_oe),
    .x_accel_in(x_accel_in),
    .y_accel_in(y_accel_in),
    .temp_in(temp_in),
    .self_test_x(self_test_x),
    .self_test_y(self_test_y),
    .measure_mode(measure_mode)
  );

  icl_master_bfm u_icl_master_bfm (
    .sys_clk(sys_clk),
    .chip_select_n(chip_select_n),
    .sck(sck),
    .mosi(mosi),
    .miso(miso_w),
    .rx_valid(rx_valid),
    .rx_data(rx_data)
  );

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  task automatic check_word(input string name, input logic [15:0] e,
                            input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_bit(input string name, input logic e,
                           input logic g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic complete_run();
    if (exp_q.size() != 0) begin
      failures++;
      $display("mismatch answers expected %0d seen 0", exp_q.size());
    end
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Oldest expectation is matched against each finished answer.
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("mismatch answer expected none seen %h", rx_data);
      end else begin
        check_word("answer", exp_q.pop_front(), rx_data);
      end
    end
  end

  task automatic rd(input logic [7:0] cmd, input int n,
                    input logic [15:0] e);
    exp_q.push_back(e);
    u_icl_master_bfm.frame(cmd, 8 + n, n);
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic new_inputs();
    x_accel_in <= 11'($urandom);
    y_accel_in <= 11'($urandom);
    temp_in <= 8'($urandom);
    @(posedge sys_clk);
  endtask

  task automatic flags(input logic sx, input logic sy);
    check_bit("self_test_x", sx, self_test_x);
    check_bit("self_test_y", sy, self_test_y);
    check_bit("measure_mode", ~(sx | sy), measure_mode);
    check_bit("miso_oe", 1'b0, miso_oe);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    complete_run();
  end

  initial begin
    reset = 1'b1;
    x_accel_in = 11'h000;
    y_accel_in = 11'h000;
    temp_in = 8'h00;
    failures = 0;
    tests_run = 0;
    none_w = {5'h00, {11{1'bz}}};
    void'($urandom(32'hE43004BE));
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    flags(1'b0, 1'b0);
    new_inputs();
    ex = {5'h00, x_accel_in};
    ey = {5'h00, y_accel_in};
    et = {8'h00, temp_in};
    repeat (3100) @(posedge sys_clk);
    // Fresh inputs must not appear until a full deselected period passes.
    new_inputs();
    rd(icl_pkg::CMD_RDX, 11, ex);
    repeat (300) @(posedge sys_clk);
    rd(icl_pkg::CMD_RDY, 11, ey);
    repeat (300) @(posedge sys_clk);
    rd(icl_pkg::CMD_TEMP, 8, et);
    rd(icl_pkg::CMD_RDX, 4, {12'h000, ex[10:7]});
    u_icl_master_bfm.frame(icl_pkg::CMD_SELF_TEST_X, 5, 0);
    flags(1'b0, 1'b0);
    rd(icl_pkg::CMD_RDY, 11, ey);
    rd(8'hA5, 11, none_w);
    rd(icl_pkg::CMD_RDX, 11, ex);
    rd(icl_pkg::CMD_SELF_TEST_X, 11, none_w);
    flags(1'b1, 1'b0);
    rd(icl_pkg::CMD_RDX, 11, ex);
    flags(1'b1, 1'b0);
    rd(icl_pkg::CMD_MEASURE, 11, none_w);
    flags(1'b0, 1'b0);
    rd(icl_pkg::CMD_SELF_TEST_Y, 11, none_w);
    flags(1'b0, 1'b1);
    rd(icl_pkg::CMD_MEASURE, 11, none_w);
    flags(1'b0, 1'b0);
    u_icl_master_bfm.junk();
    repeat (10) @(posedge sys_clk);
    flags(1'b0, 1'b0);
    ex = {5'h00, x_accel_in};
    ey = {5'h00, y_accel_in};
    et = {8'h00, temp_in};
    repeat (3100) @(posedge sys_clk);
    rd(icl_pkg::CMD_RDX, 11, ex);
    rd(icl_pkg::CMD_RDY, 11, ey);
    rd(icl_pkg::CMD_TEMP, 8, et);
    repeat (10) @(posedge sys_clk);
    complete_run();
  end
endmodule
